// ### verilog/tpm_pkg.sv
// Constants, types and register layout for the transceiver power-mode block.
package tpm_pkg;

  // Register addresses on the control port.
  localparam logic [7:0] ADDR_MODE     = 8'h01;
  localparam logic [7:0] ADDR_STATUS   = 8'h03;
  localparam logic [7:0] ADDR_WAKE_CFG = 8'h04;
  localparam logic [7:0] ADDR_EVENTS   = 8'h05;

  // Status register field positions.
  localparam int unsigned STAT_SLEEP_CAUSE_BIT    = 7;
  localparam int unsigned STAT_NORMAL_ENTERED_BIT = 5;

  // Operating modes, coded as the mode select field codes where one exists.
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_SLEEP    = 3'h1,
    MODE_OVERTEMP = 3'h2,
    MODE_STANDBY  = 3'h4,
    MODE_NORMAL   = 3'h7
  } tpm_mode_e;

  // Wake configuration register, bits 4:0.
  typedef struct packed {
    logic local_wake_falling_enable;
    logic local_wake_rising_enable;
    logic selective_config_valid;
    logic selective_wake_enable;
    logic bus_wake_enable;
  } tpm_wake_cfg_s;

  localparam logic [4:0] WAKE_CFG_RST = 5'h00;

  // Pending event register, bits 3:0.
  typedef struct packed {
    logic serial_fault_event;
    logic local_fall;
    logic local_rise;
    logic bus_wake;
  } tpm_events_s;

  localparam logic [3:0] EVENTS_RST      = 4'h0;
  localparam logic [3:0] WAKE_EVENT_MASK = 4'h7;

  // Level pins from the analog side, all asynchronous to the clock.
  typedef struct packed {
    logic battery_above_pon;
    logic battery_below_poff;
    logic vcc_under;
    logic vio_under;
    logic temp_above_act;
    logic temp_below_rel;
    logic wake_pin;
    logic bus_wake_std;
    logic bus_wake_sel;
  } tpm_pin_in_s;

  // Registered pin controls.
  typedef struct packed {
    logic inh_oe;
    logic inh_o;
    logic bus_active;
    logic wake_monitor;
    logic selective_mode;
    logic rxd_low;
    logic serial_en;
  } tpm_pin_out_s;

  localparam logic [6:0] PIN_OUT_RST = 7'h00;

  // Timing: clock period and delays, rounded up to whole cycles.
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned T_STARTUP_US    = 100;
  localparam int unsigned T_UVD_US        = 10;
  localparam int unsigned T_UVD_SLEEP_US  = 20;
  localparam int unsigned STARTUP_CYC =
    (T_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UVD_CYC =
    (T_UVD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UVD_SLEEP_CYC =
    (T_UVD_SLEEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### verilog/tpm_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module tpm_sync #(
  parameter int unsigned WIDTH = 9
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("tpm_sync: WIDTH must be at least 1.");
    end
  endgenerate

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ### verilog/tpm_timer.sv
// Delay counter that raises done once run has held for CYCLES clocks.
`timescale 1ns/1ps
`default_nettype none
module tpm_timer #(
  parameter int unsigned CYCLES = 4
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic run,
  output logic      done
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES);

  logic [W-1:0] cnt_r;

  generate
    if (CYCLES < 1)
    begin : g_chk
      $error("tpm_timer: CYCLES must be at least 1.");
    end
  endgenerate

  assign done = (cnt_r == LAST);

  // Dropping run restarts the count, so a glitchy level never accumulates.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_r <= '0;
    else if (!run)
      cnt_r <= '0;
    else if (!done)
      cnt_r <= cnt_r + W'(1);
  end

endmodule
`default_nettype wire

// ### verilog/tpm_mode_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_mode_fsm (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Events from the serial logic
  input  wire logic        serial_fault_event,
  // Asynchronous analog levels
  input  wire logic [8:0]  pins_async,
  // Pin controls and state
  output tpm_pkg::tpm_pin_out_s pin_ctl,
  output tpm_pkg::tpm_mode_e    mode_state
);

  tpm_pkg::tpm_mode_e    mode_r;
  tpm_pkg::tpm_mode_e    mode_nxt;
  tpm_pkg::tpm_wake_cfg_s cfg_r;
  tpm_pkg::tpm_wake_cfg_s cfg_nxt;
  tpm_pkg::tpm_events_s  pend_r;
  tpm_pkg::tpm_events_s  pend_nxt;
  tpm_pkg::tpm_events_s  ev_set;
  tpm_pkg::tpm_pin_in_s  pin_s;
  tpm_pkg::tpm_pin_out_s out_nxt;
  logic [8:0]            pins_sync;
  logic                  sleep_cause_r;
  logic                  normal_entered_r;
  logic [7:0]            rdata_r;
  logic                  wake_r;
  logic                  bus_std_r;
  logic                  bus_sel_r;

  // Modes in which the inhibit pin drives the battery level.
  function automatic logic inh_driven(input tpm_pkg::tpm_mode_e m);
    inh_driven = (m == tpm_pkg::MODE_STANDBY) || (m == tpm_pkg::MODE_NORMAL)
              || (m == tpm_pkg::MODE_OVERTEMP);
  endfunction

  // Low-power modes that behave alike on the bus side.
  function automatic logic low_power(input tpm_pkg::tpm_mode_e m);
    low_power = (m == tpm_pkg::MODE_STANDBY) || (m == tpm_pkg::MODE_SLEEP);
  endfunction

  tpm_sync #(
    .WIDTH (9)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (pins_async),
    .q     (pins_sync)
  );

  assign pin_s = pins_sync;

  wire batt_low  = pin_s.battery_below_poff;
  wire uv_level  = pin_s.vcc_under | pin_s.vio_under;
  wire vio_ok    = ~pin_s.vio_under;

  // Startup delay runs while the battery is present in Off.
  wire startup_run = (mode_r == tpm_pkg::MODE_OFF) & pin_s.battery_above_pon
                   & ~batt_low;
  wire startup_done;
  wire uvd_done;
  wire uvs_done;

  tpm_timer #(
    .CYCLES (tpm_pkg::STARTUP_CYC)
  ) u_startup (
    .clock (clock),
    .rst   (rst),
    .run   (startup_run),
    .done  (startup_done)
  );

  tpm_timer #(
    .CYCLES (tpm_pkg::UVD_CYC)
  ) u_uvd (
    .clock (clock),
    .rst   (rst),
    .run   (uv_level),
    .done  (uvd_done)
  );

  tpm_timer #(
    .CYCLES (tpm_pkg::UVD_SLEEP_CYC)
  ) u_uvs (
    .clock (clock),
    .rst   (rst),
    .run   (uvd_done),
    .done  (uvs_done)
  );

  // Register decode and mode requests.
  wire       mode_wr = reg_wr && (reg_addr == tpm_pkg::ADDR_MODE);
  wire       cfg_wr  = reg_wr && (reg_addr == tpm_pkg::ADDR_WAKE_CFG);
  wire       evt_wr  = reg_wr && (reg_addr == tpm_pkg::ADDR_EVENTS);
  wire [2:0] cmd     = reg_wdata[2:0];
  wire cmd_normal  = mode_wr && (cmd == tpm_pkg::MODE_NORMAL);
  wire cmd_standby = mode_wr && (cmd == tpm_pkg::MODE_STANDBY);
  wire cmd_sleep   = mode_wr && (cmd == tpm_pkg::MODE_SLEEP);

  wire wake_pending = |(pend_r & tpm_pkg::WAKE_EVENT_MASK);
  wire wake_source  = cfg_r.bus_wake_enable | cfg_r.local_wake_rising_enable
                    | cfg_r.local_wake_falling_enable;
  wire sleep_ok     = ~wake_pending & wake_source;

  wire uv_force = uvs_done && !batt_low && ((mode_r == tpm_pkg::MODE_STANDBY)
                  || (mode_r == tpm_pkg::MODE_NORMAL));

  // serial fault does not end Sleep
  wire sleep_wake = wake_pending;

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      tpm_pkg::MODE_OFF:
        if (startup_done)
          mode_nxt = tpm_pkg::MODE_STANDBY;
      tpm_pkg::MODE_NORMAL:
        if (pin_s.temp_above_act)
          mode_nxt = tpm_pkg::MODE_OVERTEMP;
        else if (uv_force)
          mode_nxt = tpm_pkg::MODE_SLEEP;
        else if (cmd_standby)
          mode_nxt = tpm_pkg::MODE_STANDBY;
        else if (cmd_sleep)
          mode_nxt = sleep_ok ? tpm_pkg::MODE_SLEEP : tpm_pkg::MODE_STANDBY;
      tpm_pkg::MODE_STANDBY:
        if (uv_force)
          mode_nxt = tpm_pkg::MODE_SLEEP;
        else if (cmd_normal)
          mode_nxt = tpm_pkg::MODE_NORMAL;
        else if (cmd_sleep)
          mode_nxt = sleep_ok ? tpm_pkg::MODE_SLEEP : tpm_pkg::MODE_STANDBY;
      tpm_pkg::MODE_SLEEP:
        if (sleep_wake)
          mode_nxt = tpm_pkg::MODE_STANDBY;
        else if (cmd_normal && vio_ok)
          mode_nxt = tpm_pkg::MODE_NORMAL;
        else if (cmd_standby && vio_ok)
          mode_nxt = tpm_pkg::MODE_STANDBY;
      tpm_pkg::MODE_OVERTEMP:
        if (pin_s.temp_below_rel)
          mode_nxt = tpm_pkg::MODE_STANDBY;
      default:
        mode_nxt = tpm_pkg::MODE_OFF;
    endcase
    if (batt_low)
      mode_nxt = tpm_pkg::MODE_OFF;
  end

  // wake detection, selective only with a valid configuration
  wire bus_watch = cfg_r.bus_wake_enable && low_power(mode_r);
  wire sel_mode  = cfg_r.selective_wake_enable && cfg_r.selective_config_valid;
  wire bus_edge  = sel_mode ? (pin_s.bus_wake_sel & ~bus_sel_r)
                            : (pin_s.bus_wake_std & ~bus_std_r);
  wire detect_on = low_power(mode_r) || (mode_r == tpm_pkg::MODE_NORMAL);

  assign ev_set.bus_wake   = bus_watch & bus_edge;
  assign ev_set.local_rise = detect_on & cfg_r.local_wake_rising_enable
                           & pin_s.wake_pin & ~wake_r;
  assign ev_set.local_fall = detect_on & cfg_r.local_wake_falling_enable
                           & ~pin_s.wake_pin & wake_r;
  assign ev_set.serial_fault_event = detect_on & serial_fault_event;

  // forced entry clears events; a new event in that cycle still wins
  wire [3:0] evt_clr = (uv_force || mode_r == tpm_pkg::MODE_OFF) ? 4'hf
                     : (evt_wr ? reg_wdata[3:0] : 4'h0);
  assign pend_nxt = (pend_r & ~evt_clr) | ev_set;

  // wake enables restored on forced entry
  assign cfg_nxt = uv_force ? tpm_pkg::tpm_wake_cfg_s'({1'b1, 1'b1,
                     cfg_r.selective_config_valid, 1'b0, 1'b1})
                 : (cfg_wr ? tpm_pkg::tpm_wake_cfg_s'(reg_wdata[4:0]) : cfg_r);

  // pin controls follow the next mode
  assign out_nxt.inh_oe         = inh_driven(mode_nxt);
  assign out_nxt.inh_o          = inh_driven(mode_nxt);
  assign out_nxt.bus_active     = (mode_nxt == tpm_pkg::MODE_NORMAL);
  assign out_nxt.wake_monitor   = cfg_nxt.bus_wake_enable & low_power(mode_nxt);
  assign out_nxt.selective_mode = out_nxt.wake_monitor
                                & cfg_nxt.selective_wake_enable
                                & cfg_nxt.selective_config_valid;
  assign out_nxt.rxd_low        = (|pend_nxt)
                                & (low_power(mode_nxt)
                                   || mode_nxt == tpm_pkg::MODE_OVERTEMP);
  assign out_nxt.serial_en      = low_power(mode_nxt)
                                || (mode_nxt == tpm_pkg::MODE_NORMAL);

  // Register read values; the mode field reads back the current mode.
  wire [7:0] status_val = {sleep_cause_r, 1'b0, normal_entered_r, 5'h00};
  wire [7:0] rd_val =
      (reg_addr == tpm_pkg::ADDR_MODE)     ? {5'h00, mode_r}
    : (reg_addr == tpm_pkg::ADDR_STATUS)   ? status_val
    : (reg_addr == tpm_pkg::ADDR_WAKE_CFG) ? {3'h0, cfg_r}
    : (reg_addr == tpm_pkg::ADDR_EVENTS)   ? {4'h0, pend_r}
    : 8'h00;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_r  <= tpm_pkg::MODE_OFF;
      cfg_r   <= tpm_pkg::WAKE_CFG_RST;
      pend_r  <= tpm_pkg::EVENTS_RST;
      pin_ctl <= tpm_pkg::PIN_OUT_RST;
    end
    else
    begin
      mode_r  <= mode_nxt;
      cfg_r   <= cfg_nxt;
      pend_r  <= pend_nxt;
      pin_ctl <= out_nxt;
    end
  end

  // Edge history for wake inputs, taken from synchronised levels only.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wake_r    <= 1'b0;
      bus_std_r <= 1'b0;
      bus_sel_r <= 1'b0;
    end
    else
    begin
      wake_r    <= pin_s.wake_pin;
      bus_std_r <= pin_s.bus_wake_std;
      bus_sel_r <= pin_s.bus_wake_sel;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sleep_cause_r    <= 1'b0;
      normal_entered_r <= 1'b1;
    end
    else
    begin
      if (uv_force)
        sleep_cause_r <= 1'b1;
      else if (mode_nxt == tpm_pkg::MODE_SLEEP && mode_r != tpm_pkg::MODE_SLEEP)
        sleep_cause_r <= 1'b0;
      if (mode_r == tpm_pkg::MODE_OFF)
        normal_entered_r <= 1'b1;
      else if (mode_nxt == tpm_pkg::MODE_NORMAL)
        normal_entered_r <= 1'b0;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= reg_rd ? rd_val : 8'h00;
  end

  assign reg_rdata  = rdata_r;
  assign mode_state = mode_r;

  default clocking dflt_cb @(posedge clock);
  endclocking

  default disable iff (rst);

  sequence startup_seq;
    startup_run ##1 startup_run [*3];
  endsequence

  // startup length counter
  // The startup delay is far longer than a delay range may reach, so the
  // cycles spent waiting in Off are counted here and bounded above.
  localparam logic [11:0] STARTUP_MAX = 12'(tpm_pkg::STARTUP_CYC + 1);
  logic [11:0] off_wait_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      off_wait_r <= 12'h000;
    else if ((mode_r == tpm_pkg::MODE_OFF) && startup_run)
      off_wait_r <= off_wait_r + 12'h001;
    else
      off_wait_r <= 12'h000;
  end

  sequence standby_sleep_req_s;
    (mode_r == tpm_pkg::MODE_STANDBY) && cmd_sleep && !uv_force && !batt_low;
  endsequence

  mode_legal_a : assert property (
    mode_r inside {tpm_pkg::MODE_OFF, tpm_pkg::MODE_SLEEP,
                   tpm_pkg::MODE_OVERTEMP, tpm_pkg::MODE_STANDBY,
                   tpm_pkg::MODE_NORMAL})
    else $error("Mode register holds an illegal code.");

  normal_cmd_a : assert property (
    (mode_r == tpm_pkg::MODE_STANDBY) && cmd_normal && !uv_force && !batt_low
    |=> (mode_r == tpm_pkg::MODE_NORMAL) && pin_ctl.bus_active)
    else $error("Normal request from Standby not honoured.");

  inh_pin_a : assert property (
    $changed(mode_r) |-> pin_ctl.inh_oe == (mode_r != tpm_pkg::MODE_SLEEP
                                         && mode_r != tpm_pkg::MODE_OFF))
    else $error("Inhibit enable does not match mode.");

  rxd_wake_a : assert property (
    (mode_r == tpm_pkg::MODE_STANDBY) && (|pend_r) |-> pin_ctl.rxd_low)
    else $error("Receive output not low with event pending.");

  startup_a : assert property (
    startup_seq |-> off_wait_r <= STARTUP_MAX)
    else $error("Startup did not reach Standby in time.");

  overtemp_a : assert property (
    (mode_r == tpm_pkg::MODE_NORMAL) && pin_s.temp_above_act && !batt_low
    |=> mode_r == tpm_pkg::MODE_OVERTEMP ##1 !pin_ctl.bus_active)
    else $error("Overtemp not entered at once from Normal.");

  sleep_wake_a : assert property (
    (mode_r == tpm_pkg::MODE_SLEEP) && wake_pending && !batt_low
    |=> mode_r == tpm_pkg::MODE_STANDBY)
    else $error("Sleep not left on pending wake event.");

  sleep_refuse_a : assert property (
    standby_sleep_req_s |=> (mode_r == tpm_pkg::MODE_SLEEP) == $past(sleep_ok))
    else $error("Sleep admission decided wrongly.");

  uv_force_a : assert property (
    uv_force |=> (mode_r == tpm_pkg::MODE_SLEEP || batt_low)
                 && cfg_r.bus_wake_enable && !cfg_r.selective_wake_enable
                 && sleep_cause_r)
    else $error("Forced Sleep entry incomplete.");

  off_entry_a : assert property (
    batt_low |=> (mode_r == tpm_pkg::MODE_OFF) ##1 !pin_ctl.inh_oe)
    else $error("Battery loss did not force Off.");

  normal_flag_a : assert property (
    (mode_r == tpm_pkg::MODE_NORMAL) |-> !normal_entered_r)
    else $error("Normal-entered flag still set in Normal.");

  bad_code_a : assert property (
    mode_wr && !(cmd inside {3'h1, 3'h4, 3'h7}) && !uv_force && !batt_low
    && (mode_r == tpm_pkg::MODE_STANDBY) |=> $stable(mode_r))
    else $error("Undefined mode code changed the mode.");

endmodule
`default_nettype wire

// ### verif/tpm_host_model.sv
// Host controller model driving the register port of the mode block.
`timescale 1ns/1ps
`default_nettype none
module tpm_host_model (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    // Released lines carry the inverse, so a stale value never passes.
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge clock);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### verif/tpm_mode_fsm_test.sv
// Self-checking bench for the transceiver power-mode block.
`timescale 1ns/1ps
`default_nettype none
module tpm_mode_fsm_test;
  localparam logic [7:0] AM = tpm_pkg::ADDR_MODE;
  localparam logic [7:0] AS = tpm_pkg::ADDR_STATUS;
  localparam logic [7:0] AC = tpm_pkg::ADDR_WAKE_CFG;
  localparam logic [7:0] AE = tpm_pkg::ADDR_EVENTS;
  logic                  clock;
  logic                  rst;
  logic [7:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [7:0]            reg_rdata;
  logic                  serial_fault_event;
  tpm_pkg::tpm_pin_in_s  pin;
  tpm_pkg::tpm_pin_out_s pin_ctl;
  tpm_pkg::tpm_mode_e    mode_state;
  logic [7:0]            rdv;
  int                    bad_count;
  int                    tests_run;
  int                    waited;

  tpm_mode_fsm i_tpm_mode_fsm (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_fault_event(serial_fault_event), .pins_async(pin),
    .pin_ctl(pin_ctl), .mode_state(mode_state));

  tpm_host_model i_tpm_host_model (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  initial
  begin
    clock = 1'b0;
    forever
    begin
      #25 clock = ~clock;
    end
  end

  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    i_tpm_host_model.wr(a, d);
    @(negedge clock);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m, input string msg);
    i_tpm_host_model.rd(a, rdv);
    chk((rdv & m) === e, msg);
  endtask

  task automatic wait_mode(input tpm_pkg::tpm_mode_e m, input int lim);
    waited = 0;
    while (mode_state !== m && waited < lim)
    begin
      @(negedge clock);
      waited++;
    end
    if (mode_state !== m)
    begin
      chk(1'b0, "mode wait timed out");
      conclude();
    end
  endtask

  // Wake frame on one bus wake line, toggled every 200 ns (four clocks), giving a 400 ns period.
  task automatic link_burst(input bit sel);
    repeat (8)
    begin
      repeat (4) @(posedge clock);
      if (sel)
        pin.bus_wake_sel <= ~pin.bus_wake_sel;
      else
        pin.bus_wake_std <= ~pin.bus_wake_std;
    end
    repeat (4) @(negedge clock);
  endtask

  task automatic fault_pulse();
    @(posedge clock);
    serial_fault_event <= 1'b1;
    @(posedge clock);
    serial_fault_event <= 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic t_power_up();
    chk(mode_state === tpm_pkg::MODE_OFF && !pin_ctl.inh_oe, "not off");
    rc(AS, 8'h20, 8'ha0, "status after reset");
    @(posedge clock);
    pin.battery_above_pon <= 1'b1;
    wait_mode(tpm_pkg::MODE_STANDBY, tpm_pkg::STARTUP_CYC + 20);
    chk(waited >= tpm_pkg::STARTUP_CYC, "startup too short");
    chk(pin_ctl.inh_oe === 1'b1 && pin_ctl.bus_active === 1'b0, "standby");
    chk(pin_ctl.inh_o === 1'b1, "inhibit level");
  endtask

  task automatic t_commands();
    mw(AM, 8'h07);
    chk(mode_state === tpm_pkg::MODE_NORMAL && pin_ctl.bus_active === 1'b1, "normal");
    rc(AM, 8'h07, 8'hff, "mode readback");
    rc(AS, 8'h00, 8'h20, "normal flag kept");
    for (int c = 0; c < 8; c++)
      if (c != 1 && c != 4 && c != 7)
      begin
        mw(AM, 8'(c));
        chk(mode_state === tpm_pkg::MODE_NORMAL, "unknown code acted");
      end
    mw(8'h10, 8'hff);
    rc(8'h10, 8'h00, 8'hff, "unmapped read");
    mw(AS, 8'hff);
    rc(AS, 8'h00, 8'ha0, "status written");
    mw(AM, 8'h04);
    chk(mode_state === tpm_pkg::MODE_STANDBY, "standby code");
  endtask

  task automatic t_sleep();
    mw(AC, 8'h00);
    mw(AM, 8'h01);
    chk(mode_state === tpm_pkg::MODE_STANDBY, "sleep with no source");
    mw(AC, 8'h01);
    mw(AM, 8'h01);
    chk(mode_state === tpm_pkg::MODE_SLEEP && !pin_ctl.inh_oe, "sleep");
    rc(AS, 8'h00, 8'h80, "cause by command");
    fault_pulse();
    chk(mode_state === tpm_pkg::MODE_SLEEP && pin_ctl.rxd_low, "fault woke");
    mw(AE, 8'hff);
    link_burst(1'b0);
    chk(mode_state === tpm_pkg::MODE_STANDBY, "bus wake");
    chk(pin_ctl.rxd_low === 1'b1 && pin_ctl.wake_monitor === 1'b1, "rx");
    rc(AE, 8'h01, 8'h0f, "bus wake event");
    mw(AM, 8'h01);
    chk(mode_state === tpm_pkg::MODE_STANDBY, "slept while pending");
    mw(AE, 8'hff);
    chk(pin_ctl.rxd_low === 1'b0, "rx low after clear");
    mw(AM, 8'h01);
    mw(AM, 8'h07);
    chk(mode_state === tpm_pkg::MODE_NORMAL, "normal from sleep");
    mw(AM, 8'h04);
  endtask

  task automatic t_selective();
    mw(AC, 8'h07);
    chk(pin_ctl.selective_mode === 1'b1, "selective off");
    link_burst(1'b0);
    rc(AE, 8'h00, 8'h01, "pattern woke selective");
    link_burst(1'b1);
    rc(AE, 8'h01, 8'h01, "frame ignored");
    mw(AE, 8'hff);
    mw(AC, 8'h03);
    chk(pin_ctl.selective_mode === 1'b0, "selective without valid");
  endtask

  task automatic t_overtemp();
    mw(AM, 8'h07);
    pin.temp_above_act <= 1'b1;
    wait_mode(tpm_pkg::MODE_OVERTEMP, 6);
    pin.temp_above_act <= 1'b0;
    mw(AM, 8'h04);
    chk(mode_state === tpm_pkg::MODE_OVERTEMP, "left while hot");
    pin.temp_below_rel <= 1'b1;
    wait_mode(tpm_pkg::MODE_STANDBY, 6);
    pin.temp_below_rel <= 1'b0;
  endtask

  task automatic t_undervolt();
    mw(AC, 8'h02);
    mw(AM, 8'h07);
    fault_pulse();
    @(posedge clock);
    pin.vcc_under <= 1'b1;
    wait_mode(tpm_pkg::MODE_SLEEP, 620);
    chk(waited >= tpm_pkg::UVD_CYC + tpm_pkg::UVD_SLEEP_CYC, "early");
    pin.vcc_under <= 1'b0;
    rc(AC, 8'h19, 8'h1f, "forced wake config");
    rc(AE, 8'h00, 8'h0f, "events kept");
    rc(AS, 8'h80, 8'h80, "cause not undervoltage");
    mw(AM, 8'h04);
    chk(mode_state === tpm_pkg::MODE_STANDBY, "command wake");
  endtask

  task automatic t_power_off();
    @(posedge clock);
    pin.battery_below_poff <= 1'b1;
    wait_mode(tpm_pkg::MODE_OFF, 6);
    chk(!pin_ctl.inh_oe && !pin_ctl.serial_en, "off pins");
  endtask

  initial
  begin
    rst = 1'b1;
    serial_fault_event = 1'b0;
    pin = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_power_up();
    t_commands();
    t_sleep();
    t_selective();
    t_overtemp();
    t_undervolt();
    t_power_off();
    conclude();
  end
endmodule
`default_nettype wire
